// ---- shared/psl_pkg.sv ----
// Purpose: shared constants of the peripheral serial link
// Assumes: one command byte, then up to fifteen data bytes per frame
// Notes:   status and node path layouts live here

package psl_pkg;

  // ********************************************************
  // widths and limits
  // ********************************************************
  localparam int          DATA_W     = 8;
  localparam int          REG_W      = 6;
  localparam int          CNT_W      = 4;
  localparam logic [3:0]  MAX_DATA   = 4'hf;
  localparam int          FIFO_DEPTH = 32;

  // ********************************************************
  // command byte: op in [7:6], register number in [5:0]
  // ********************************************************
  localparam int          OP_POS     = 6;
  localparam logic [1:0]  OP_WRITE   = 2'h0;
  localparam logic [1:0]  OP_READ    = 2'h1;
  localparam logic [1:0]  OP_ECHO    = 2'h2;

  // ********************************************************
  // status byte layout and reset value
  // ********************************************************
  localparam int          ST_STATE_POS  = 6;
  localparam int          ST_ROUTER_POS = 5;
  localparam int          ST_COMM_POS   = 4;
  localparam int          ST_UNEXEC_POS = 1;
  localparam int          ST_WDOG_POS   = 0;
  localparam logic [1:0]  ST_RESERVED   = 2'h0;
  localparam logic [1:0]  ST_READY      = 2'h1;
  localparam logic [1:0]  ST_BUSY       = 2'h2;
  localparam logic [1:0]  ST_NOCONN     = 2'h3;
  localparam logic [7:0]  STATUS_RST    = 8'h40;
  localparam logic [7:0]  FILL_BYTE     = 8'h00;

  // ********************************************************
  // node path byte fields
  // ********************************************************
  localparam int          NP_PORT_POS = 6;
  localparam int          NP_PORT_W   = 2;
  localparam int          NP_L1_POS   = 3;
  localparam int          NP_L1_W     = 3;
  localparam int          NP_L2_POS   = 0;
  localparam int          NP_L2_W     = 3;

  typedef enum logic [2:0] {
    PSL_IDLE,
    PSL_CMD,
    PSL_WR,
    PSL_RD,
    PSL_ECHO,
    PSL_SKIP
  } psl_state_t;

endpackage

// ---- rtl/psl_fifo.sv ----
// Purpose: write data buffer between the link and the user side
// Assumes: one clock; DEPTH is a power of two
// Notes:   read data leave through an output register

`timescale 1ns/1ps

module psl_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_sys,
  input  wire logic             arst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
      $error("psl_fifo: DEPTH must be a power of two, 2 or more");
    end
  endgenerate

  // ********************************************************
  // storage and pointers
  // ********************************************************
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign push     = in_valid & in_ready;
  assign pop      = (count != '0) & (~out_valid | out_ready);

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + AW'(1);
      end
      if (push && !pop) begin
        count <= count + (AW+1)'(1);
      end else if (pop && !push) begin
        count <= count - (AW+1)'(1);
      end
    end
  end

  // ********************************************************
  // output register
  // ********************************************************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data  <= mem[rd_ptr];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

endmodule

// ---- rtl/psl_link.sv ----
// Purpose: peripheral end of a select/clock/data serial link
// Assumes: master makes link_clk and stops it between frames
// Notes:   link bytes cross to clk_sys by a toggle handshake
//
// Summary of operation
// - a seen select makes this end selected and obey commands.
// - with several peripherals, the first byte is the target address.
// - without addressing, selected at once on select, with no further qualification.
// - once connected, bytes move out and in at the same time.
// - the connection lasts exactly while select stays asserted.
// - node path: port in 7..6, level one 5..3, level two 2..0.
// - a write sends a register number, then 0 to 15 data bytes.
// - a read sends a register number, then returns 0 to 15 bytes.
// - a zero length transfer is only the register number byte.
// - echo returns the very character the master sent.
// - every frame returns the status of the previous command.
// - status bits 7..6: 00 reserved, 01 ready, 10 busy, 11 absent.
// - status bit 1 is 0 if last command accepted, else 1.

`timescale 1ns/1ps

module psl_link #(
  parameter bit ADDRESSED  = 1'b0,
  parameter int FIFO_DEPTH = psl_pkg::FIFO_DEPTH
) (
  input  wire logic                      clk_sys,
  input  wire logic                      arst_n,
  input  wire logic                      link_clk,
  input  wire logic                      link_sel_n,
  input  wire logic                      link_mosi,
  output logic                           link_miso,
  input  wire logic [7:0]                node_path,
  output logic                           wr_valid,
  input  wire logic                      wr_ready,
  output logic [psl_pkg::REG_W-1:0]      wr_reg,
  output logic [psl_pkg::DATA_W-1:0]     wr_data,
  output logic                           rd_req,
  output logic [psl_pkg::REG_W-1:0]      rd_reg,
  output logic [psl_pkg::CNT_W-1:0]      rd_index,
  input  wire logic [psl_pkg::DATA_W-1:0] rd_data,
  output logic [7:0]                     status_byte,
  output logic                           frame_active
);

  localparam int FW = psl_pkg::REG_W + psl_pkg::DATA_W;

  generate
    if (FIFO_DEPTH < 2) begin : g_bad
      $error("psl_link: FIFO_DEPTH too small");
    end
  endgenerate

  // ********************************************************
  // link domain: shift registers
  // ********************************************************
  logic       link_clr;
  logic [2:0] bit_cnt;
  logic       first;
  logic [6:0] rx_sh;
  logic [7:0] tx_sh;
  logic [7:0] out_byte;
  logic [7:0] rx_byte;
  logic       rx_first;
  logic       rx_tgl;
  logic [7:0] tx_byte;

  // deselect clears framing without waiting for a clock edge
  assign link_clr = link_sel_n | ~arst_n;
  // byte 0 always carries the held status
  assign out_byte = first ? status_byte : tx_sh;

  always_ff @(posedge link_clk or posedge link_clr) begin
    if (link_clr) begin
      bit_cnt   <= 3'h0;
      first     <= 1'b1;
      rx_sh     <= 7'h0;
      tx_sh     <= 8'h0;
      link_miso <= 1'b0;
    end else begin
      rx_sh   <= {rx_sh[5:0], link_mosi};
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == 3'h0) begin
        link_miso <= out_byte[7];
        tx_sh     <= {out_byte[6:0], 1'b0};
      end else if (bit_cnt == 3'h7) begin
        // sys side only changes tx_byte after this toggle lands
        first     <= 1'b0;
        link_miso <= tx_sh[7];
        tx_sh     <= tx_byte;
      end else begin
        link_miso <= tx_sh[7];
        tx_sh     <= {tx_sh[6:0], 1'b0};
      end
    end
  end

  // kept out of the select clear so the toggle never jumps
  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_byte  <= 8'h0;
      rx_first <= 1'b0;
      rx_tgl   <= 1'b0;
    end else if (!link_sel_n && bit_cnt == 3'h7) begin
      rx_byte  <= {rx_sh, link_mosi};
      rx_first <= first;
      rx_tgl   <= ~rx_tgl;
    end
  end

  // ********************************************************
  // crossings into clk_sys
  // ********************************************************
  logic       tgl_s1;
  logic       tgl_s2;
  logic       tgl_s3;
  logic       sel_n_s1;
  logic       sel_n_s2;
  logic       sel_n_s3;
  logic       sel_n_s4;
  logic [7:0] np_s1;
  logic [7:0] np_s2;
  logic       rx_ev;
  logic       frame_end;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tgl_s1   <= 1'b0;
      tgl_s2   <= 1'b0;
      tgl_s3   <= 1'b0;
      sel_n_s1 <= 1'b1;
      sel_n_s2 <= 1'b1;
      sel_n_s3 <= 1'b1;
      sel_n_s4 <= 1'b1;
      np_s1    <= 8'h0;
      np_s2    <= 8'h0;
    end else begin
      tgl_s1   <= rx_tgl;
      tgl_s2   <= tgl_s1;
      tgl_s3   <= tgl_s2;
      sel_n_s1 <= link_sel_n;
      sel_n_s2 <= sel_n_s1;
      sel_n_s3 <= sel_n_s2;
      sel_n_s4 <= sel_n_s3;
      np_s1    <= node_path;
      np_s2    <= np_s1;
    end
  end

  assign rx_ev     = tgl_s2 ^ tgl_s3;
  // one cycle late so the last byte is always handled first
  assign frame_end = sel_n_s3 & ~sel_n_s4;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      frame_active <= 1'b0;
    end else begin
      frame_active <= ~sel_n_s2;
    end
  end

  // ********************************************************
  // byte decode
  // ********************************************************
  logic [1:0]              rx_op;
  logic [psl_pkg::REG_W-1:0] rx_reg;
  logic                    is_addr;
  logic                    is_cmd;
  logic                    addr_hit;
  logic                    data_full;
  psl_pkg::psl_state_t     state;
  logic [psl_pkg::CNT_W-1:0] data_cnt;

  assign rx_op  = rx_byte[psl_pkg::OP_POS +: 2];
  assign rx_reg = rx_byte[psl_pkg::REG_W-1:0];

  assign is_addr = rx_first & ADDRESSED;
  assign is_cmd  = rx_first ? ~ADDRESSED : (state == psl_pkg::PSL_CMD);

  assign addr_hit =
    (rx_byte[psl_pkg::NP_PORT_POS +: psl_pkg::NP_PORT_W] ==
     np_s2[psl_pkg::NP_PORT_POS +: psl_pkg::NP_PORT_W]) &&
    (rx_byte[psl_pkg::NP_L1_POS +: psl_pkg::NP_L1_W] ==
     np_s2[psl_pkg::NP_L1_POS +: psl_pkg::NP_L1_W]) &&
    (rx_byte[psl_pkg::NP_L2_POS +: psl_pkg::NP_L2_W] ==
     np_s2[psl_pkg::NP_L2_POS +: psl_pkg::NP_L2_W]);

  assign data_full = (data_cnt == psl_pkg::MAX_DATA);

  // ********************************************************
  // command state machine
  // ********************************************************
  logic [psl_pkg::REG_W-1:0] cmd_reg;
  logic                      unexec;
  logic                      comm_err;
  logic                      got_cmd;
  logic                      got_addr;
  logic                      fifo_in_ready;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state    <= psl_pkg::PSL_IDLE;
      cmd_reg  <= '0;
      data_cnt <= '0;
      unexec   <= 1'b0;
      comm_err <= 1'b0;
      got_cmd  <= 1'b0;
      got_addr <= 1'b0;
    end else if (frame_end) begin
      state    <= psl_pkg::PSL_IDLE;
      data_cnt <= '0;
      unexec   <= 1'b0;
      comm_err <= 1'b0;
      got_cmd  <= 1'b0;
      got_addr <= 1'b0;
    end else if (rx_ev) begin
      if (is_addr) begin
        got_addr <= addr_hit;
        state    <= addr_hit ? psl_pkg::PSL_CMD : psl_pkg::PSL_SKIP;
      end else if (is_cmd) begin
        got_cmd  <= 1'b1;
        cmd_reg  <= rx_reg;
        data_cnt <= '0;
        case (rx_op)
          psl_pkg::OP_WRITE: state <= psl_pkg::PSL_WR;
          psl_pkg::OP_READ:  state <= psl_pkg::PSL_RD;
          psl_pkg::OP_ECHO:  state <= psl_pkg::PSL_ECHO;
          default: begin
            state  <= psl_pkg::PSL_SKIP;
            unexec <= 1'b1;
          end
        endcase
      end else begin
        case (state)
          psl_pkg::PSL_WR,
          psl_pkg::PSL_RD: begin
            // a sixteenth data byte is dropped
            if (data_full) begin
              unexec <= 1'b1;
            end else begin
              data_cnt <= data_cnt + 4'h1;
              if (state == psl_pkg::PSL_WR && !fifo_in_ready) begin
                comm_err <= 1'b1;
              end
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ********************************************************
  // write path into the buffer
  // ********************************************************
  logic          push_valid;
  logic [FW-1:0] push_data;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      push_valid <= 1'b0;
      push_data  <= '0;
    end else begin
      // full buffer refuses the byte rather than stall the master
      push_valid <= rx_ev && !is_addr && !is_cmd && !data_full &&
                    state == psl_pkg::PSL_WR && fifo_in_ready;
      push_data  <= {cmd_reg, rx_byte};
    end
  end

  psl_fifo #(
    .WIDTH (FW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .in_valid  (push_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (push_data),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  ({wr_reg, wr_data})
  );

  // ********************************************************
  // read requests and outgoing data
  // ********************************************************

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rd_req   <= 1'b0;
      rd_reg   <= '0;
      rd_index <= '0;
    end else begin
      rd_req <= 1'b0;
      if (rx_ev && is_cmd && rx_op == psl_pkg::OP_READ) begin
        rd_req   <= 1'b1;
        rd_reg   <= rx_reg;
        rd_index <= '0;
      end else if (rx_ev && !is_addr && !is_cmd &&
                   state == psl_pkg::PSL_RD &&
                   data_cnt < psl_pkg::MAX_DATA - 4'h1) begin
        rd_req   <= 1'b1;
        rd_index <= data_cnt + 4'h1;
      end
    end
  end

  // one byte of turnaround: reply to byte k leaves in byte k+2
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tx_byte <= psl_pkg::FILL_BYTE;
    end else if (frame_end) begin
      // a stale reply must not lead the next frame
      tx_byte <= psl_pkg::FILL_BYTE;
    end else if (rd_req) begin
      tx_byte <= rd_data;
    end else if (rx_ev) begin
      if (!is_addr && !is_cmd && state == psl_pkg::PSL_ECHO) begin
        tx_byte <= rx_byte;
      end else begin
        tx_byte <= psl_pkg::FILL_BYTE;
      end
    end
  end

  // ********************************************************
  // status of the previous command
  // ********************************************************
  logic [1:0] dev_state;

  assign dev_state = fifo_in_ready ? psl_pkg::ST_READY
                                   : psl_pkg::ST_BUSY;

  // held steady between frames; byte 0 of a frame reads it
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      status_byte <= psl_pkg::STATUS_RST;
    end else if (frame_end && (!ADDRESSED || got_addr)) begin
      status_byte <= '0;
      status_byte[psl_pkg::ST_STATE_POS +: 2] <= dev_state;
      status_byte[psl_pkg::ST_ROUTER_POS]     <= 1'b0;
      status_byte[psl_pkg::ST_COMM_POS]       <= comm_err;
      status_byte[psl_pkg::ST_UNEXEC_POS]     <= unexec | ~got_cmd;
      status_byte[psl_pkg::ST_WDOG_POS]       <= 1'b0;
    end
  end

endmodule

// ---- testbench/psl_link_props.sv ----
// Purpose: concurrent checks on the serial link block ports
// Assumes: either addressing mode; master parks link_clk between frames
// Notes:   a bit counter rebuilds which status bit is on the wire

`timescale 1ns/1ps

module psl_link_props #(
  parameter bit ADDRESSED  = 1'b0,
  parameter int FIFO_DEPTH = 32
) (
  input wire logic       clk_sys,
  input wire logic       arst_n,
  input wire logic       link_clk,
  input wire logic       link_sel_n,
  input wire logic       link_mosi,
  input wire logic       link_miso,
  input wire logic [7:0] node_path,
  input wire logic       wr_valid,
  input wire logic       wr_ready,
  input wire logic [5:0] wr_reg,
  input wire logic [7:0] wr_data,
  input wire logic       rd_req,
  input wire logic [5:0] rd_reg,
  input wire logic [3:0] rd_index,
  input wire logic [7:0] rd_data,
  input wire logic [7:0] status_byte,
  input wire logic       frame_active
);
  // ********************************************************
  // helper: link bits seen, cleared by release of select
  // ********************************************************
  logic [7:0] bit_cnt;

  always_ff @(posedge link_clk or posedge link_sel_n) begin
    if (link_sel_n) begin
      bit_cnt <= 8'h00;
    end else if (bit_cnt != 8'hff) begin
      bit_cnt <= bit_cnt + 8'h01;
    end
  end

  // ********************************************************
  // properties
  // ********************************************************
  property p_miso_idle;
    @(posedge clk_sys) disable iff (!arst_n)
      link_sel_n && $past(link_sel_n) |-> !link_miso;
  endproperty
  a_miso_idle: assert property (p_miso_idle)
    else $error("miso driven while deselected");

  property p_sel_seen;
    @(posedge clk_sys) disable iff (!arst_n)
      $fell(link_sel_n) |-> ##[1:4] frame_active;
  endproperty
  a_sel_seen: assert property (p_sel_seen)
    else $error("select not seen in time");

  property p_desel;
    @(posedge clk_sys) disable iff (!arst_n)
      $rose(link_sel_n) |-> ##[1:4] !frame_active;
  endproperty
  a_desel: assert property (p_desel)
    else $error("frame still open after release");

  property p_rd_pulse;
    @(posedge clk_sys) disable iff (!arst_n) rd_req |=> !rd_req [*8];
  endproperty
  a_rd_pulse: assert property (p_rd_pulse)
    else $error("read request too long or too close");

  property p_rd_index;
    @(posedge clk_sys) disable iff (!arst_n) rd_req |-> rd_index <= 4'he;
  endproperty
  a_rd_index: assert property (p_rd_index)
    else $error("read index beyond fifteen bytes");

  property p_wr_hold;
    @(posedge clk_sys) disable iff (!arst_n) wr_valid && !wr_ready
      |=> wr_valid && $stable(wr_data) && $stable(wr_reg);
  endproperty
  a_wr_hold: assert property (p_wr_hold)
    else $error("write byte lost before taken");

  property p_status_fields;
    @(posedge clk_sys) disable iff (!arst_n)
      status_byte[7:6] != psl_pkg::ST_RESERVED &&
      (status_byte & 8'h2d) == 8'h00;
  endproperty
  a_status_fields: assert property (p_status_fields)
    else $error("status byte field out of range");

  // status leaves msb first in the opening byte of each frame
  property p_status_out;
    @(negedge link_clk) disable iff (!arst_n || link_sel_n)
      bit_cnt >= 8'h01 && bit_cnt <= 8'h08
      |-> link_miso == status_byte[8'h08 - bit_cnt];
  endproperty
  a_status_out: assert property (p_status_out)
    else $error("opening byte differs from status");

  c_write: cover property (@(posedge clk_sys) wr_valid && wr_ready);
  c_read: cover property (@(posedge clk_sys) rd_req && rd_index == 4'he);
  c_busy: cover property (@(posedge clk_sys) status_byte[7:6] == 2'h2);
endmodule

bind psl_link psl_link_props #(
  .ADDRESSED  (ADDRESSED),
  .FIFO_DEPTH (FIFO_DEPTH)
) u_props (
  .clk_sys, .arst_n, .link_clk, .link_sel_n, .link_mosi, .link_miso,
  .node_path, .wr_valid, .wr_ready, .wr_reg, .wr_data, .rd_req,
  .rd_reg, .rd_index, .rd_data, .status_byte, .frame_active
);

// ---- testbench/psl_master.sv ----
// Purpose: behavioural master driving select, link clock and commands
// Assumes: 64 ns link period, clock parked low between frames
// Notes:   slow adds idle half periods between bytes

`timescale 1ns/1ps

module psl_master (
  output logic      link_clk,
  output logic      link_sel_n,
  output logic      link_mosi,
  input  wire logic link_miso
);
  initial begin
    link_clk   = 1'b0;
    link_sel_n = 1'b1;
    link_mosi  = 1'b1;
  end

  // n_bits off a byte boundary leaves the last byte cut short
  task automatic frame(input logic [7:0] tx [$], input int n_bits,
                       input int slow, output logic [7:0] rx [$]);
    logic [7:0] cur;
    cur = 8'h00;
    rx = {};
    link_sel_n = 1'b0;
    #71;
    for (int i = 0; i < n_bits; i++) begin
      link_mosi = tx[i / 8][7 - i % 8];
      #32 link_clk = 1'b1;
      #32 link_clk = 1'b0;
      cur = {cur[6:0], link_miso};
      if (i % 8 == 7) begin
        rx.push_back(cur);
        #(32 * slow);
      end
    end
    #32 link_sel_n = 1'b1;
    link_mosi = ~link_mosi; // released line must not look held
    #300;
  endtask
endmodule

// ---- testbench/psl_link_tb_top.sv ----
// Purpose: self-checking bench for the serial link peripheral end
// Assumes: DUT default build, no addressing, 32 word write buffer; DUT_A addressed
// Notes:   master model makes link_clk; user side driven on negedge

`timescale 1ns/1ps

module psl_link_tb_top;
  logic        clk_sys, arst_n, link_clk, link_sel_n, link_mosi;
  logic        link_miso, wr_valid, wr_ready, rd_req, frame_active;
  logic [7:0]  node_path, wr_data, rd_data, status_byte;
  logic [5:0]  wr_reg, rd_reg;
  logic [3:0]  rd_index;
  logic        link_clk_a, link_sel_n_a, link_mosi_a, link_miso_a;
  logic [7:0]  status_byte_a;
  logic [13:0] wr_log [$];
  logic [7:0]  rx [$];
  int          n_errors, total_checks, n_rd;

  psl_link DUT (
    .clk_sys, .arst_n, .link_clk, .link_sel_n, .link_mosi, .link_miso,
    .node_path, .wr_valid, .wr_ready, .wr_reg, .wr_data, .rd_req,
    .rd_reg, .rd_index, .rd_data, .status_byte, .frame_active
  );

  psl_master u_master (.link_clk, .link_sel_n, .link_mosi, .link_miso);

  // addressed build, own node path 9a
  psl_link #(.ADDRESSED (1'b1)) DUT_A (
    .clk_sys, .arst_n, .link_clk (link_clk_a), .link_sel_n (link_sel_n_a),
    .link_mosi (link_mosi_a), .link_miso (link_miso_a),
    .node_path (8'h9a), .wr_valid (), .wr_ready (1'b1), .wr_reg (),
    .wr_data (), .rd_req (), .rd_reg (), .rd_index (), .rd_data (8'h00),
    .status_byte (status_byte_a), .frame_active ()
  );

  psl_master u_master_a (.link_clk (link_clk_a), .link_sel_n (link_sel_n_a),
                         .link_mosi (link_mosi_a), .link_miso (link_miso_a));

  initial clk_sys = 1'b0;
  always #12.5 clk_sys = ~clk_sys;

  // ********************************************************
  // user side: read answers and write log
  // ********************************************************
  function automatic logic [7:0] rd_byte(logic [5:0] r, logic [3:0] i);
    return {r[3:0], i} ^ 8'h5a;
  endfunction

  always @(negedge clk_sys) rd_data <= rd_byte(rd_reg, rd_index);

  always @(posedge clk_sys) begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1)
      wr_log.push_back({wr_reg, wr_data});
    if (rd_req === 1'b1)
      n_rd++;
  end

  // ********************************************************
  // shared tasks
  // ********************************************************
  task automatic results();
    if (n_errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cmp_rx(input logic [7:0] exp [$]);
    check("rx count", rx.size(), exp.size());
    foreach (exp[i]) check("rx byte", rx[i], exp[i]);
  endtask

  // a stuck write side ends the run here rather than hanging
  task automatic wait_wr(input int n);
    int k;
    k = 0;
    while (wr_log.size() < n && k < 3000) begin
      @(negedge clk_sys);
      k++;
    end
    if (wr_log.size() < n) begin
      n_errors++;
      results();
    end
  endtask

  // ********************************************************
  // scenarios
  // ********************************************************
  task automatic t_reset();
    check("status rst", status_byte, psl_pkg::STATUS_RST);
    check("frame idle", frame_active, 1'b0);
    check("miso idle", link_miso, 1'b0);
  endtask

  task automatic t_write();
    logic [7:0] tx [$];
    wr_log = {};
    u_master.frame({8'h05, 8'hab, 8'h11}, 24, 0, rx);
    cmp_rx({8'h40, 8'h00, 8'h00});
    wait_wr(2);
    check("wr first", wr_log[0], {6'h05, 8'hab});
    check("wr second", wr_log[1], {6'h05, 8'h11});
    tx = {8'h02};
    repeat (16) tx.push_back(8'h77);
    u_master.frame(tx, 136, 0, rx);
    check("wr over", wr_log.size(), 17);
    check("status long", status_byte, 8'h42);
    u_master.frame({8'h07}, 8, 0, rx);
    cmp_rx({8'h42});
    check("wr zero", wr_log.size(), 17);
    check("status", status_byte, 8'h40);
  endtask

  task automatic t_echo();
    u_master.frame({8'h80}, 4, 0, rx);
    check("status cut", status_byte, 8'h42);
    u_master.frame({8'h80, 8'h3c, 8'h5a, 8'h00, 8'h00}, 40, 0, rx);
    cmp_rx({8'h42, 8'h00, 8'h00, 8'h3c, 8'h5a});
    check("status", status_byte, 8'h40);
  endtask

  task automatic t_read();
    logic [7:0] tx [$];
    logic [7:0] exp [$];
    tx = {8'h43};
    exp = {8'h40, 8'h00};
    for (int i = 0; i < 15; i++) begin
      tx.push_back(8'h00);
      if (i < 14)
        exp.push_back(rd_byte(6'h03, i[3:0]));
    end
    n_rd = 0;
    u_master.frame(tx, 128, 2, rx);
    cmp_rx(exp);
    check("rd reqs", n_rd, 15);
  endtask

  task automatic t_full();
    logic [7:0] tx [$];
    @(negedge clk_sys) wr_ready = 1'b0;
    wr_log = {};
    for (int f = 0; f < 3; f++) begin
      tx = {8'h01};
      for (int i = 0; i < 15; i++)
        tx.push_back(8'(f * 15 + i));
      u_master.frame(tx, 128, 0, rx);
    end
    check("status full", status_byte, 8'h90);
    @(negedge clk_sys) wr_ready = 1'b1;
    wait_wr(33);
    repeat (40) @(negedge clk_sys);
    check("wr count", wr_log.size(), 33);
    foreach (wr_log[i]) begin
      check("wr byte", wr_log[i], {6'h01, 8'(i)});
    end
    u_master.frame({8'h80}, 8, 0, rx);
    cmp_rx({8'h90});
    check("status", status_byte, 8'h40);
    u_master.frame({8'hc5}, 8, 0, rx);
    cmp_rx({8'h40});
    check("status bad op", status_byte, 8'h42);
  endtask

  task automatic t_addr();
    u_master_a.frame({8'h9a, 8'hc0}, 16, 0, rx);
    check("addr hit", status_byte_a, 8'h42);
    u_master_a.frame({8'h5a, 8'h80}, 16, 0, rx);
    cmp_rx({8'h42, 8'h00});
    check("addr miss", status_byte_a, 8'h42);
    u_master_a.frame({8'h9a, 8'h80}, 16, 0, rx);
    check("addr echo", status_byte_a, 8'h40);
  endtask

  initial begin
    arst_n = 1'b0;
    wr_ready = 1'b1;
    node_path = 8'h00;
    rd_data = 8'h00;
    n_errors = 0;
    total_checks = 0;
    n_rd = 0;
    repeat (8) @(negedge clk_sys);
    arst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    t_reset();
    t_write();
    t_echo();
    t_read();
    t_full();
    t_addr();
    results();
  end
endmodule
